// file: hw/dac_bus_ctrl.sv
// Controller that writes and loads a double buffered 12-bit converter
//
// How it works
// [RULE1] Device latches hold at strobe 0, follow at 1
// [RULE2] Load strobe transfers without chip select
// [RULE3] All strobes level sensitive, no edges
// [RULE4] Every strobe pulse lasts at least 250 ns
// [RULE5] Chip select and enable overlap 250 ns
// [RULE6] Wait 200 ns after load before done
// [RULE7] Unipolar trim loads the all zero code
// [RULE8] Bipolar trim loads only MSB set
// [RULE9] Three nibble enables cover high, mid, low
// [RULE10] Converter register alone drives the output
// [RULE11] Chip select is asserted low
// [RULE12] One load strobe moves all twelve bits
// [RULE13] Nibble opens with select and enable; load alone
`timescale 1ns/1ps
module dac_bus_ctrl (
   input  wire logic                                 sys_clk,
   input  wire logic                                 resetn,
   input  wire logic                                 cmd_valid,
   output logic                                      cmd_ready,
   input  wire logic [dac_ctrl_pkg::OP_W-1:0]        cmd_op,
   input  wire logic [dac_ctrl_pkg::CODE_W-1:0]      cmd_code,
   input  wire logic [dac_ctrl_pkg::NIBBLES-1:0]     cmd_nibble_mask,
   output logic                                      done,
   output logic [dac_ctrl_pkg::CODE_W-1:0]           dac_data,
   output logic                                      chip_select_n,
   output logic                                      high_nibble_enable,
   output logic                                      mid_nibble_enable,
   output logic                                      low_nibble_enable,
   output logic                                      converter_load_strobe
);

   ////////////////////////////////////////////////////////////////////
   // Reset release

   logic                                   rst_meta;
   logic                                   rst_n;

   // Asynchronous assert, release through two flops
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Command decode and sequencing

   dac_ctrl_pkg::state_e                   state;
   dac_ctrl_pkg::state_e                   next_state;
   logic [dac_ctrl_pkg::NIBBLES-1:0]       mask;
   logic [dac_ctrl_pkg::NIBBLES-1:0]       next_mask;
   logic [dac_ctrl_pkg::CODE_W-1:0]        next_code;
   logic                                   load_after;
   logic                                   next_load_after;
   logic                                   take;
   logic                                   timer_start;
   logic [dac_ctrl_pkg::TIMER_W-1:0]       timer_length;
   logic                                   timer_last;

   assign cmd_ready = (state == dac_ctrl_pkg::ST_IDLE);
   assign take      = cmd_valid && cmd_ready;

   // What an accepted command writes, and whether it loads afterwards
   always_comb begin
      next_code       = cmd_code;
      next_mask       = cmd_nibble_mask;
      next_load_after = 1'b0;
      unique case (cmd_op)
         dac_ctrl_pkg::OP_WRITE: begin
         end
         dac_ctrl_pkg::OP_LOAD: begin
            next_mask       = dac_ctrl_pkg::MASK_NONE;
            next_load_after = 1'b1;
         end
         dac_ctrl_pkg::OP_WRITE_LOAD: begin
            next_load_after = 1'b1;
         end
         dac_ctrl_pkg::OP_TRIM_UNI: begin
            next_code       = dac_ctrl_pkg::CODE_UNIPOLAR_ZERO; // see [RULE7]
            next_mask       = dac_ctrl_pkg::MASK_ALL;
            next_load_after = 1'b1;
         end
         dac_ctrl_pkg::OP_TRIM_BI: begin
            next_code       = dac_ctrl_pkg::CODE_BIPOLAR_ZERO; // see [RULE8]
            next_mask       = dac_ctrl_pkg::MASK_ALL;
            next_load_after = 1'b1;
         end
         default: begin
            // Unknown opcodes complete at once with nothing driven
            next_mask       = dac_ctrl_pkg::MASK_NONE;
         end
      endcase
   end

   // State transitions; each strobe state lasts its whole interval
   always_comb begin
      next_state   = state;
      timer_start  = 1'b0;
      timer_length = dac_ctrl_pkg::STROBE_CYCLES;
      unique case (state)
         dac_ctrl_pkg::ST_IDLE: begin
            if (take && next_mask != dac_ctrl_pkg::MASK_NONE) begin
               next_state  = dac_ctrl_pkg::ST_WRITE;
               timer_start = 1'b1;
            end else if (take && next_load_after) begin
               next_state  = dac_ctrl_pkg::ST_LOAD;
               timer_start = 1'b1;
            end
         end
         dac_ctrl_pkg::ST_WRITE: begin
            if (timer_last) begin // see [RULE4] [RULE5]
               next_state   = dac_ctrl_pkg::ST_GAP;
               timer_start  = 1'b1;
               timer_length = dac_ctrl_pkg::GAP_CYCLES;
            end
         end
         dac_ctrl_pkg::ST_GAP: begin
            if (timer_last && load_after) begin
               next_state  = dac_ctrl_pkg::ST_LOAD;
               timer_start = 1'b1;
            end else if (timer_last) begin
               next_state  = dac_ctrl_pkg::ST_IDLE;
            end
         end
         dac_ctrl_pkg::ST_LOAD: begin
            if (timer_last) begin // see [RULE4]
               next_state   = dac_ctrl_pkg::ST_SETTLE;
               timer_start  = 1'b1;
               timer_length = dac_ctrl_pkg::SETTLE_CYCLES;
            end
         end
         dac_ctrl_pkg::ST_SETTLE: begin
            if (timer_last) begin // see [RULE6]
               next_state = dac_ctrl_pkg::ST_IDLE;
            end
         end
      endcase
   end

   strobe_timer u_timer (
      .clk    (sys_clk),
      .rst_n  (rst_n),
      .start  (timer_start),
      .length (timer_length),
      .last   (timer_last)
   );

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= dac_ctrl_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Command held for the whole sequence
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mask       <= dac_ctrl_pkg::MASK_NONE;
         load_after <= 1'b0;
      end else if (take) begin
         mask       <= next_mask;
         load_after <= next_load_after;
      end
   end

   // Completion pulse after settle, after the gap of a write without load, or for a command that does nothing
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         done <= 1'b0;
      end else begin
         done <= (state == dac_ctrl_pkg::ST_SETTLE && timer_last)
              || (state == dac_ctrl_pkg::ST_GAP && timer_last
                  && !load_after)
              || (take && next_state == dac_ctrl_pkg::ST_IDLE);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Pins

   // Data bus changes only on acceptance, at the same edge that select falls and
   // the enables rise, and stays stable long after any strobe falls
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dac_data <= dac_ctrl_pkg::CODE_RESET;
      end else if (take && next_mask != dac_ctrl_pkg::MASK_NONE) begin
         dac_data <= next_code;
      end
   end

   // Strobes are registered from next_state so they never glitch;
   // the device latches are transparent, a glitch would corrupt them
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         chip_select_n      <= 1'b1;
         high_nibble_enable <= 1'b0;
         mid_nibble_enable  <= 1'b0;
         low_nibble_enable  <= 1'b0;
      end else if (next_state == dac_ctrl_pkg::ST_WRITE) begin // see [RULE9]
         // Select low and enables high together for the full width
         chip_select_n      <= 1'b0; // see [RULE11] [RULE13] [RULE3]
         high_nibble_enable <= (take ? next_mask[dac_ctrl_pkg::MASK_HIGH]
                                     : mask[dac_ctrl_pkg::MASK_HIGH]);
         mid_nibble_enable  <= (take ? next_mask[dac_ctrl_pkg::MASK_MID]
                                     : mask[dac_ctrl_pkg::MASK_MID]);
         low_nibble_enable  <= (take ? next_mask[dac_ctrl_pkg::MASK_LOW]
                                     : mask[dac_ctrl_pkg::MASK_LOW]);
      end else begin
         // Dropping to 0 makes the device hold the nibbles
         chip_select_n      <= 1'b1; // see [RULE1]
         high_nibble_enable <= 1'b0;
         mid_nibble_enable  <= 1'b0;
         low_nibble_enable  <= 1'b0;
      end
   end

   // Load strobe runs with chip select released; one pulse moves all
   // nibbles into the converter register at once
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         converter_load_strobe <= 1'b0;
      end else begin
         converter_load_strobe <= // see [RULE2] [RULE12]
            (next_state == dac_ctrl_pkg::ST_LOAD); // see [RULE10]
      end
   end

endmodule

// file: hw/dac_ctrl_pkg.sv
// Shared constants for the double buffered converter bus controller
package dac_ctrl_pkg;

   // Clock and pin timing
   localparam int  SYS_CLK_HZ        = 25_000_000;
   localparam int  STROBE_MIN_NS     = 250;
   localparam int  OUTPUT_DELAY_NS   = 200;
   localparam int  NS_PER_S          = 1_000_000_000;
   localparam int  CLK_PERIOD_NS     = NS_PER_S / SYS_CLK_HZ;

   // Least times round up to whole cycles
   localparam int  STROBE_CYCLES_I   =
      (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int  SETTLE_CYCLES_I   =
      (OUTPUT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int  TIMER_W           = 4;
   localparam logic [TIMER_W-1:0] STROBE_CYCLES =
      TIMER_W'(STROBE_CYCLES_I);
   localparam logic [TIMER_W-1:0] SETTLE_CYCLES =
      TIMER_W'(SETTLE_CYCLES_I);
   localparam logic [TIMER_W-1:0] GAP_CYCLES    = 4'h1;
   localparam logic [TIMER_W-1:0] TIMER_LAST    = 4'h1;
   localparam logic [TIMER_W-1:0] TIMER_IDLE    = 4'h0;

   // Code layout: three nibbles, most significant first
   localparam int  CODE_W            = 12;
   localparam int  NIBBLES           = 3;
   localparam int  MASK_HIGH         = 2;
   localparam int  MASK_MID          = 1;
   localparam int  MASK_LOW          = 0;
   localparam logic [NIBBLES-1:0] MASK_ALL  = 3'h7;
   localparam logic [NIBBLES-1:0] MASK_NONE = 3'h0;

   // Trim codes and the data bus reset code
   localparam logic [CODE_W-1:0] CODE_UNIPOLAR_ZERO = 12'h000;
   localparam logic [CODE_W-1:0] CODE_BIPOLAR_ZERO  = 12'h800;
   localparam logic [CODE_W-1:0] CODE_RESET         = 12'h000;

   // Command opcodes
   localparam int  OP_W              = 3;
   localparam logic [OP_W-1:0] OP_WRITE      = 3'h0;
   localparam logic [OP_W-1:0] OP_LOAD       = 3'h1;
   localparam logic [OP_W-1:0] OP_WRITE_LOAD = 3'h2;
   localparam logic [OP_W-1:0] OP_TRIM_UNI   = 3'h3;
   localparam logic [OP_W-1:0] OP_TRIM_BI    = 3'h4;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_WRITE,
      ST_GAP,
      ST_LOAD,
      ST_SETTLE
   } state_e;

endpackage

// file: hw/strobe_timer.sv
// Down counter that times strobe, gap and settle intervals
`timescale 1ns/1ps
module strobe_timer (
   input  wire logic                             clk,
   input  wire logic                             rst_n,
   input  wire logic                             start,
   input  wire logic [dac_ctrl_pkg::TIMER_W-1:0] length,
   output logic                                  last
);

   logic [dac_ctrl_pkg::TIMER_W-1:0] count;

   // Loaded on start, then counts down to idle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= dac_ctrl_pkg::TIMER_IDLE;
      end else if (start) begin
         count <= length;
      end else if (count != dac_ctrl_pkg::TIMER_IDLE) begin
         count <= count - dac_ctrl_pkg::TIMER_LAST;
      end
   end

   // High in the final cycle of an interval of length cycles
   assign last = (count == dac_ctrl_pkg::TIMER_LAST);

endmodule

// file: dv/dac_dev_model.sv
// Behavioural model of the double buffered converter latches
`timescale 1ns/1ps
module dac_dev_model (
   input  wire logic        chip_select_n,
   input  wire logic        high_nibble_enable,
   input  wire logic        mid_nibble_enable,
   input  wire logic        low_nibble_enable,
   input  wire logic        converter_load_strobe,
   input  wire logic [11:0] dac_data,
   output logic      [11:0] dac_out,
   output logic             viol
);
   logic [3:0]  hi;
   logic [3:0]  mi;
   logic [3:0]  lo;
   logic [11:0] dreg;
   time         t_o;
   time         t_l;
   wire         sel  = !chip_select_n;
   wire         open = sel && (high_nibble_enable || mid_nibble_enable
                               || low_nibble_enable);
   ////////////////////////////////////////////////////////////////////
   // Input stages follow while opened, hold at strobe 0
   always_latch if (sel && high_nibble_enable)
      hi <= dac_data[11:8];
   always_latch if (sel && mid_nibble_enable)
      mi <= dac_data[7:4];
   always_latch if (sel && low_nibble_enable)
      lo <= dac_data[3:0];
   // Load path ignores chip select; only this register reaches out
   always_latch if (converter_load_strobe)
      dreg <= {hi, mi, lo};
   assign #200 dac_out = dreg;
   ////////////////////////////////////////////////////////////////////
   // Pulses shorter than the least width are flagged to the bench
   initial viol = 1'b0;
   always @(posedge open) t_o = $time;
   always @(negedge open)
      if ($time - t_o < 250) viol = 1'b1;
   always @(posedge converter_load_strobe) t_l = $time;
   always @(negedge converter_load_strobe)
      if ($time - t_l < 250) viol = 1'b1;
endmodule

// file: dv/dac_bus_ctrl_chk.sv
// Pin timing checker for the converter bus controller
`timescale 1ns/1ps
module dac_bus_ctrl_chk (
   input wire logic        sys_clk,
   input wire logic        resetn,
   input wire logic        cmd_valid,
   input wire logic        cmd_ready,
   input wire logic [2:0]  cmd_op,
   input wire logic [11:0] cmd_code,
   input wire logic [2:0]  cmd_nibble_mask,
   input wire logic        done,
   input wire logic [11:0] dac_data,
   input wire logic        chip_select_n,
   input wire logic        high_nibble_enable,
   input wire logic        mid_nibble_enable,
   input wire logic        low_nibble_enable,
   input wire logic        converter_load_strobe
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   wire logic [2:0] en = {high_nibble_enable, mid_nibble_enable,
                          low_nibble_enable};
   wire logic       take = cmd_valid && cmd_ready;
   wire logic       ld = converter_load_strobe;
   ////////////////////////////////////////////////////////////////////
   // Strobes stay active for the least width, seven cycles here
   a_select_width: assert property (
      $fell(chip_select_n) |-> (!chip_select_n)[*7])
      else $error("select too short");
   a_load_width: assert property (
      $rose(ld) |-> ld[*7])
      else $error("load too short");
   // Enables only inside select, and select never without one
   a_enable_in_select: assert property (
      |en |-> !chip_select_n)
      else $error("enable outside select");
   a_select_with_enable: assert property (
      $fell(chip_select_n) |-> |en)
      else $error("select without enable");
   a_load_apart: assert property (
      ld |-> chip_select_n)
      else $error("load during select");
   // Five settle cycles after the load strobe falls, then done
   a_settle_done: assert property (
      $fell(ld) |-> (!done)[*5] ##1 done)
      else $error("settle wait wrong");
   a_data_held: assert property (
      !chip_select_n && !$past(chip_select_n) |-> $stable(dac_data))
      else $error("data moved");
   a_write_opens: assert property (
      take && cmd_op == 3'h0 && cmd_nibble_mask != 3'h0 |=>
         en == $past(cmd_nibble_mask) && dac_data == $past(cmd_code))
      else $error("write open wrong");
   a_trim_zero: assert property (
      take && cmd_op == 3'h3 |=> dac_data == 12'h000 && en == 3'h7)
      else $error("unipolar trim code");
   a_trim_mid: assert property (
      take && cmd_op == 3'h4 |=> dac_data == 12'h800 && en == 3'h7)
      else $error("bipolar trim code");
   // A command taken in the done cycle may itself finish at once
   a_done_ready: assert property (
      done |-> cmd_ready ##1 (!done || $past(take)))
      else $error("done pulse wrong");
endmodule
bind dac_bus_ctrl dac_bus_ctrl_chk u_chk (
   .sys_clk(sys_clk), .resetn(resetn), .cmd_valid(cmd_valid),
   .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_code(cmd_code),
   .cmd_nibble_mask(cmd_nibble_mask), .done(done), .dac_data(dac_data),
   .chip_select_n(chip_select_n), .high_nibble_enable(high_nibble_enable),
   .mid_nibble_enable(mid_nibble_enable),
   .low_nibble_enable(low_nibble_enable),
   .converter_load_strobe(converter_load_strobe));

// file: dv/tb.sv
// Self-checking bench for the converter bus controller
`timescale 1ns/1ps
module tb;
   logic        sys_clk;
   logic        resetn;
   logic        cmd_valid;
   logic        cmd_ready;
   logic        done;
   logic [2:0]  cmd_op;
   logic [2:0]  cmd_nibble_mask;
   logic [11:0] cmd_code;
   logic [11:0] dac_data;
   logic [11:0] dac_out;
   logic        cs_n;
   logic        high_nibble_enable;
   logic        mid_nibble_enable;
   logic        low_nibble_enable;
   logic        load;
   logic        viol;
   int          n_errors = 0;
   int          tests_run = 0;
   initial sys_clk = 1'b0;
   always #20 sys_clk = ~sys_clk;
   dac_bus_ctrl u_dut (.sys_clk(sys_clk), .resetn(resetn),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
      .cmd_code(cmd_code), .cmd_nibble_mask(cmd_nibble_mask), .done(done),
      .dac_data(dac_data), .chip_select_n(cs_n),
      .high_nibble_enable(high_nibble_enable),
      .mid_nibble_enable(mid_nibble_enable),
      .low_nibble_enable(low_nibble_enable),
      .converter_load_strobe(load));
   dac_dev_model u_dev (.chip_select_n(cs_n),
      .high_nibble_enable(high_nibble_enable),
      .mid_nibble_enable(mid_nibble_enable),
      .low_nibble_enable(low_nibble_enable),
      .converter_load_strobe(load), .dac_data(dac_data),
      .dac_out(dac_out), .viol(viol));
   ////////////////////////////////////////////////////////////////////
   task automatic check(input logic [11:0] got, input logic [11:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask
   task final_report;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // One command, driven at falling edges; counts edges up to done.
   // Always starts on a fresh falling edge, since the previous call returns
   // just after a rising edge unless its command did nothing, and valid must not move there
   task automatic run(input logic [2:0] op, input logic [11:0] code,
                      input logic [2:0] mask, input logic [11:0] cyc);
      int n;
      n = 0;
      @(negedge sys_clk);
      while (cmd_ready !== 1'b1) @(negedge sys_clk);
      cmd_op = op;
      cmd_code = code;
      cmd_nibble_mask = mask;
      cmd_valid = 1'b1;
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      // A command that does nothing shows done at its taking edge
      while (done !== 1'b1 && n < 64) begin
         @(posedge sys_clk);
         n++;
         #1;
      end
      check(12'(n), cyc);
   endtask
   ////////////////////////////////////////////////////////////////////
   task t_idle;
      check({cs_n, high_nibble_enable, mid_nibble_enable, low_nibble_enable,
             load, done, cmd_ready, 5'h00}, 12'h820);
      check(dac_data, 12'h000);
   endtask
   task t_full;
      run(3'h2, 12'hA5C, 3'h7, 12'h014);
      check(dac_out, 12'hA5C);
   endtask
   // Partial write must not reach the output before a load
   task t_part;
      run(3'h0, 12'h1F2, 3'h5, 12'h008);
      check(dac_out, 12'hA5C);
      run(3'h1, 12'h000, 3'h0, 12'h00C);
      check(dac_out, 12'h152);
      run(3'h2, 12'h0E0, 3'h2, 12'h014);
      check(dac_out, 12'h1E2);
   endtask
   task t_trim;
      run(3'h3, 12'hFFF, 3'h0, 12'h014);
      check(dac_out, 12'h000);
      run(3'h4, 12'h123, 3'h0, 12'h014);
      check(dac_out, 12'h800);
   endtask
   // Empty mask and unknown opcode finish at once, pins untouched
   task t_noop;
      run(3'h0, 12'hFFF, 3'h0, 12'h000);
      run(3'h7, 12'hFFF, 3'h7, 12'h000);
      check(dac_data, 12'h800);
      check(dac_out, 12'h800);
      check({11'h000, viol}, 12'h000);
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      resetn = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = 3'h0;
      cmd_code = 12'h000;
      cmd_nibble_mask = 3'h0;
      repeat (12) @(posedge sys_clk);
      @(negedge sys_clk);
      resetn = 1'b1;
      repeat (3) @(negedge sys_clk);
      t_idle();
      t_full();
      t_part();
      t_trim();
      t_noop();
      final_report();
   end
   // Hang guard, far beyond the roughly 130 cycles the run needs
   initial begin
      #200000;
      $display("ERROR %0t watchdog expired", $time);
      n_errors++;
      final_report();
   end
endmodule
